// *** hdl/pprs_top.sv ***
// pll power-down, pll reset, gear shift, lock wait and phy reset sequencer
`include "pprs_regs.svh"

// Operation
// - hold pll power-down for programmed cycles
// - gear shift drops programmed cycles after reset
// - phy reset held cycles after calibration done
// - lock declared programmed cycles after reset release
// - pll reset held cycles after power-down release
// - all counts in configuration clock cycles
// - control bits other than restart stay set until written zero, restart reads back as zero
// - gear shift select enables rapid locking
module pprs_top
    import pprs_pkg::*;
#(
    parameter logic [15:0] LOCK_WAIT_RESET = `PPRS_LOCK_RESET,
    parameter logic [12:0] RST_HOLD_RESET  = `PPRS_RST_RESET
)(
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    input  wire pprs_axi_req_t i_axi,
    output wire pprs_axi_rsp_t o_axi,
    input  wire logic          i_cal_done,
    output wire pprs_pins_t    o_pins
);

    // register state
    logic [31:0]   timing0;
    logic [15:0]   lock_wait;
    logic [12:0]   rst_hold;
    logic          pd_ctl;
    logic          rst_ctl;
    logic          rapid;

    // bus state
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic [11:0]   wr_addr;
    logic [31:0]   wr_data;
    logic [3:0]    wr_strb;

    // sequencer state
    pprs_state_t   state;
    pprs_state_t   next_state;
    pprs_pins_t    pins;
    pprs_pins_t    next_pins;
    logic [15:0]   load_value;
    logic          phase_expired;
    logic          gs_expired;

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction

    // a phase of n cycles loads n-1, zero still gives one cycle
    function automatic logic [15:0] minus_one(input logic [15:0] n);
        return (n == 16'h0000) ? 16'h0000 : n - 16'h0001;
    endfunction

    // address decode, write once both address and data are held
    wire        aw_fire   = i_axi.awvalid & awready;
    wire        w_fire    = i_axi.wvalid & wready;
    wire        wr_go     = ~awready & ~wready & ~bvalid;
    wire        sel_t0    = wr_addr == `PPRS_OFF_TIMING0;
    wire        sel_t1    = wr_addr == `PPRS_OFF_TIMING1;
    wire        sel_ctl   = wr_addr == `PPRS_OFF_CONTROL;
    wire        sel_st    = wr_addr == `PPRS_OFF_STATUS;
    wire        wr_hit    = sel_t0 | sel_t1 | sel_ctl | sel_st;
    wire [31:0] t1_word   = {lock_wait, 3'h0, rst_hold};
    wire [31:0] ctl_word  = {28'h0, 1'b0, rapid, rst_ctl, pd_ctl};
    wire [31:0] st_word   = {27'h0, pins.phy_reset, pins.pll_locked, pins.pll_gearshift,
                             pins.pll_reset, pins.pll_powerdown};
    wire [31:0] t0_new    = merge(timing0, wr_data, wr_strb);
    wire [31:0] t1_new    = merge(t1_word, wr_data, wr_strb);
    wire [31:0] ctl_new   = merge(ctl_word, wr_data, wr_strb);
    wire        restart   = wr_go & sel_ctl & wr_strb[0] & wr_data[`PPRS_CTL_RESTART_BIT];

    // read decode
    wire        ar_fire   = i_axi.arvalid & arready;
    wire        rd_t0     = i_axi.araddr == `PPRS_OFF_TIMING0;
    wire        rd_t1     = i_axi.araddr == `PPRS_OFF_TIMING1;
    wire        rd_ctl    = i_axi.araddr == `PPRS_OFF_CONTROL;
    wire        rd_st     = i_axi.araddr == `PPRS_OFF_STATUS;
    wire        rd_hit    = rd_t0 | rd_t1 | rd_ctl | rd_st;
    wire [31:0] rd_word   = rd_t0  ? timing0 :
                            rd_t1  ? t1_word :
                            rd_ctl ? ctl_word :
                            rd_st  ? st_word : 32'h00000000;

    // write channels, each taken on its own, response after both
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= `PPRS_RESP_OKAY;
            wr_addr <= 12'h000;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end
        else
        begin
            if (aw_fire)
            begin
                awready <= 1'b0;
                wr_addr <= {i_axi.awaddr[11:2], 2'b00};
            end
            if (w_fire)
            begin
                wready  <= 1'b0;
                wr_data <= i_axi.wdata;
                wr_strb <= i_axi.wstrb;
            end
            if (wr_go)
            begin
                bvalid <= 1'b1;
                bresp  <= wr_hit ? `PPRS_RESP_OKAY : `PPRS_RESP_SLVERR;
            end
            else if (bvalid & i_axi.bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rresp   <= `PPRS_RESP_OKAY;
            rdata   <= 32'h00000000;
        end
        else if (ar_fire)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= rd_hit ? `PPRS_RESP_OKAY : `PPRS_RESP_SLVERR;
        end
        else if (rvalid & i_axi.rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // software registers; control bits other than restart stay until written zero
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            timing0   <= `PPRS_TIMING0_RESET;
            lock_wait <= LOCK_WAIT_RESET;
            rst_hold  <= RST_HOLD_RESET;
            pd_ctl    <= 1'b0;
            rst_ctl   <= 1'b0;
            rapid     <= `PPRS_CTL_RAPID_RESET;
        end
        else if (wr_go)
        begin
            if (sel_t0)
                timing0 <= t0_new;
            if (sel_t1)
            begin
                lock_wait <= t1_new[`PPRS_LOCK_HI:`PPRS_LOCK_LO];
                rst_hold  <= t1_new[`PPRS_RST_HI:`PPRS_RST_LO];
            end
            if (sel_ctl)
            begin
                pd_ctl  <= ctl_new[`PPRS_CTL_PD_BIT];
                rst_ctl <= ctl_new[`PPRS_CTL_RST_BIT];
                rapid   <= ctl_new[`PPRS_CTL_RAPID_BIT];
            end
        end
    end

    // phase order; a restart goes straight back to power-down
    always_comb
    begin
        next_state = state;
        if (restart)
            next_state = PPRS_PWRDN;
        else
        begin
            unique case (state)
                PPRS_IDLE:     next_state = PPRS_PWRDN;
                PPRS_PWRDN:    if (phase_expired) next_state = PPRS_PLL_RESET_CONTROL;
                PPRS_PLL_RESET_CONTROL:   if (phase_expired) next_state = PPRS_LOCKWAIT;
                PPRS_LOCKWAIT: if (phase_expired) next_state = PPRS_CALWAIT;
                PPRS_CALWAIT:  if (i_cal_done) next_state = PPRS_PHYRST;
                PPRS_PHYRST:   if (phase_expired) next_state = PPRS_DONE;
                PPRS_DONE:     next_state = PPRS_DONE;
            endcase
        end
    end

    // phase length picked by the phase being entered, in config clock cycles
    wire        phase_load = restart | (next_state != state);
    wire        gs_load    = phase_load & (next_state == PPRS_LOCKWAIT);
    wire [15:0] pd_cycles  = 16'(timing0[`PPRS_PD_HI:`PPRS_PD_LO]);
    wire [15:0] gs_cycles  = 16'(timing0[`PPRS_GS_HI:`PPRS_GS_LO]);
    wire [15:0] phy_cycles = 16'(timing0[`PPRS_PHYRST_HI:`PPRS_PHYRST_LO]);
    assign load_value = (next_state == PPRS_PWRDN)    ? minus_one(pd_cycles) :
                        (next_state == PPRS_PLL_RESET_CONTROL)   ? minus_one(16'(rst_hold)) :
                        (next_state == PPRS_LOCKWAIT) ? minus_one(lock_wait) :
                                                        minus_one(phy_cycles);

    pprs_counter #(.W(16)) u_phase (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_load    (phase_load),
        .i_count   (load_value),
        .o_expired (phase_expired)
    );

    // gear shift runs beside the lock wait, both from reset release
    pprs_counter #(.W(16)) u_gearshift (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_load    (gs_load),
        .i_count   (minus_one(gs_cycles)),
        .o_expired (gs_expired)
    );

    // pin values follow the next state so they change with the state register
    wire pre_release = (next_state == PPRS_PWRDN) | (next_state == PPRS_PLL_RESET_CONTROL) |
                       (next_state == PPRS_IDLE);
    wire gs_running  = gs_load | ~gs_expired;
    // a restart written together with a new rapid select must not glitch the pin
    wire rapid_now   = (wr_go & sel_ctl) ? ctl_new[`PPRS_CTL_RAPID_BIT] : rapid;
    always_comb
    begin
        next_pins.pll_powerdown = pd_ctl | (next_state == PPRS_PWRDN);
        next_pins.pll_reset     = rst_ctl | pre_release;
        next_pins.pll_gearshift = rapid_now & (pre_release | gs_running);
        next_pins.pll_locked    = (next_state == PPRS_CALWAIT) |
                                  (next_state == PPRS_PHYRST) | (next_state == PPRS_DONE);
        next_pins.phy_reset     = next_state != PPRS_DONE;
    end

    // state and pins; power-down, pll reset and phy reset start asserted
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            state <= PPRS_IDLE;
            pins  <= '{pll_powerdown: 1'b1, pll_reset: 1'b1, pll_gearshift: 1'b0,
                       pll_locked: 1'b0, phy_reset: 1'b1};
        end
        else
        begin
            state <= next_state;
            pins  <= next_pins;
        end
    end

    // outputs are the flops themselves
    assign o_pins = pins;
    assign o_axi  = '{awready: awready, wready: wready, bresp: bresp, bvalid: bvalid,
                      arready: arready, rdata: rdata, rresp: rresp, rvalid: rvalid};

endmodule

// *** common/pprs_regs.svh ***
// register offsets, field positions, reset values of the pll and phy reset sequencer
`ifndef PPRS_REGS_SVH
`define PPRS_REGS_SVH

`define PPRS_ADDR_W            12
`define PPRS_OFF_TIMING0       12'h000
`define PPRS_OFF_TIMING1       12'h004
`define PPRS_OFF_CONTROL       12'h008
`define PPRS_OFF_STATUS        12'h00C

// timing register 0 fields
`define PPRS_PD_HI             31
`define PPRS_PD_LO             21
`define PPRS_GS_HI             20
`define PPRS_GS_LO             6
`define PPRS_PHYRST_HI         5
`define PPRS_PHYRST_LO         0
`define PPRS_TIMING0_RESET     32'h42C2158F

// timing register 1 fields, bits 15..13 read as zero
`define PPRS_LOCK_HI           31
`define PPRS_LOCK_LO           16
`define PPRS_RST_HI            12
`define PPRS_RST_LO            0
`define PPRS_LOCK_RESET        16'hD056
`define PPRS_RST_RESET         13'h12C0

// control register bits
`define PPRS_CTL_PD_BIT        0
`define PPRS_CTL_RST_BIT       1
`define PPRS_CTL_RAPID_BIT     2
`define PPRS_CTL_RESTART_BIT   3
`define PPRS_CTL_RAPID_RESET   1'b1

// counts run at the configuration clock, defaults assume 533 MHz
`define PPRS_CFG_CLK_MHZ       533

`define PPRS_RESP_OKAY         2'h0
`define PPRS_RESP_SLVERR       2'h2

`endif

// *** common/pprs_pkg.sv ***
// types shared by the pll and phy reset sequencer
package pprs_pkg;

    typedef enum logic [2:0] {
        PPRS_IDLE,
        PPRS_PWRDN,
        PPRS_PLL_RESET_CONTROL,
        PPRS_LOCKWAIT,
        PPRS_CALWAIT,
        PPRS_PHYRST,
        PPRS_DONE
    } pprs_state_t;

    // axi4-lite request from master
    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } pprs_axi_req_t;

    // axi4-lite response from slave
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } pprs_axi_rsp_t;

    // pins towards the pll macros and the phy
    typedef struct packed {
        logic pll_powerdown;
        logic pll_reset;
        logic pll_gearshift;
        logic pll_locked;
        logic phy_reset;
    } pprs_pins_t;

endpackage

// *** hdl/pprs_counter.sv ***
// down counter that times one sequencer phase
module pprs_counter
    import pprs_pkg::*;
#(
    parameter int W = 16
)(
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output wire logic         o_expired
);

    logic [W-1:0] count;

    // load wins over the decrement so a restart is never lost
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            count <= '0;
        else if (i_load)
            count <= i_count;
        else if (count != '0)
            count <= count - W'(1);
    end

    assign o_expired = (count == '0);

endmodule

// *** verif/pprs_top_asserts.sv ***
// concurrent checks on the ports of the pll and phy reset sequencer
module pprs_top_asserts
    import pprs_pkg::*;
#(
    parameter logic [15:0] LOCK_WAIT_RESET = 16'hD056,
    parameter logic [12:0] RST_HOLD_RESET  = 13'h12C0
)(
    input wire logic          i_clock,
    input wire logic          i_rst,
    input wire pprs_axi_req_t i_axi,
    input wire pprs_axi_rsp_t o_axi,
    input wire logic          i_cal_done,
    input wire pprs_pins_t    o_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // pin order of the power-up sequence
    AST_LOCK_AFTER_RST: assert property ($rose(o_pins.pll_locked) |-> !o_pins.pll_reset)
        else $error("locked while pll in reset");
    AST_PHY_AFTER_LOCK: assert property ($fell(o_pins.phy_reset) |-> o_pins.pll_locked)
        else $error("phy reset released before lock");
    AST_PHY_AFTER_CAL: assert property ($fell(o_pins.phy_reset) |-> $past(i_cal_done, 2))
        else $error("phy reset released without calibration");
    AST_RST_AFTER_PD: assert property ($fell(o_pins.pll_reset) |-> !o_pins.pll_powerdown)
        else $error("pll reset released during power-down");
    AST_GS_START: assert property ($rose(o_pins.pll_gearshift) |-> o_pins.pll_powerdown)
        else $error("gear shift raised outside sequence start");
    AST_GS_AFTER_RST: assert property ($fell(o_pins.pll_gearshift) |-> !o_pins.pll_reset)
        else $error("gear shift released during pll reset");
    // bus answers; a held request must see a held answer
    AST_B_AFTER_AW_W: assert property ($rose(o_axi.bvalid) |-> !$past(o_axi.awready) && !$past(o_axi.wready))
        else $error("write response before address and data");
    AST_R_ANSWER: assert property (i_axi.arvalid && o_axi.arready |=> o_axi.rvalid && !o_axi.arready)
        else $error("read data late");
    AST_R_HOLD: assert property (o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
        else $error("read data dropped before taken");
    AST_R_ONE_OUT: assert property (o_axi.rvalid |-> !o_axi.arready)
        else $error("read address open while read data pending");
endmodule

bind pprs_top pprs_top_asserts #(
    .LOCK_WAIT_RESET(LOCK_WAIT_RESET),
    .RST_HOLD_RESET(RST_HOLD_RESET)
) u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_axi(i_axi), .o_axi(o_axi),
    .i_cal_done(i_cal_done), .o_pins(o_pins));

// *** verif/pprs_partner.sv ***
// calibration side model: reports done some cycles after pll lock
module pprs_partner
    import pprs_pkg::*;
#(
    parameter int CAL_DLY = 6
)(
    input  wire logic       i_clock,
    input  wire pprs_pins_t i_pins,
    input  wire logic       i_early,
    output logic            o_cal_done
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;

    // calibration only runs on a locked pll; early mode lies on purpose
    always @(posedge i_clock)
    begin
        cnt <= i_pins.pll_locked ? cnt + 1 : 0;
        o_cal_done <= i_early || (i_pins.pll_locked && cnt >= CAL_DLY);
    end
endmodule

// *** verif/test_pprs_top.sv ***
// self-checking bench for the pll and phy reset sequencer
module test_pprs_top
    import pprs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic          clock = 1'b0;
    logic          rst   = 1'b1;
    logic          early = 1'b0;
    logic          cal;
    logic          ck;
    pprs_axi_req_t req   = '0;
    pprs_axi_rsp_t rsp;
    pprs_pins_t    pins;
    pprs_pins_t    prv;
    int            error_cnt = 0;
    int            n_checks  = 0;
    int            cyc       = 0;
    int            tpr, tpf, trf, tgr, tgf, tlr, tcal, tphf;

    // 100 ns period
    always #50 clock = ~clock;

    // short reset values keep the run brief
    pprs_top #(.LOCK_WAIT_RESET(16'h0020), .RST_HOLD_RESET(13'h0010)) u_dut (
        .i_clock(clock), .i_rst(rst), .i_axi(req), .o_axi(rsp),
        .i_cal_done(cal), .o_pins(pins));
    pprs_partner u_far (.i_clock(clock), .i_pins(pins), .i_early(early), .o_cal_done(cal));

    // edge stamps of pin changes, all seen one edge late so differences hold
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        prv <= pins;
        ck  <= cal && pins.pll_locked;
        if (!prv.pll_powerdown && pins.pll_powerdown) tpr <= cyc;
        if (prv.pll_powerdown && !pins.pll_powerdown) tpf <= cyc;
        if (prv.pll_reset && !pins.pll_reset) trf <= cyc;
        if (!prv.pll_gearshift && pins.pll_gearshift) tgr <= cyc;
        if (prv.pll_gearshift && !pins.pll_gearshift) tgf <= cyc;
        if (!prv.pll_locked && pins.pll_locked) tlr <= cyc;
        if (!ck && cal && pins.pll_locked) tcal <= cyc;
        if (prv.phy_reset && !pins.phy_reset) tphf <= cyc;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end
        while (!rsp.bvalid);
        req.bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
        @(posedge clock);
    endtask

    // read: address and ready offered together, data taken at the rvalid edge
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do
            @(posedge clock);
        while (!rsp.arready);
        req.arvalid <= 1'b0;
        do
            @(posedge clock);
        while (!rsp.rvalid);
        req.rready <= 1'b0;
        chk("rdata", exp, rsp.rdata);
        chk("rresp", {30'h0, er}, {30'h0, rsp.rresp});
        @(posedge clock);
    endtask

    // waits for the sequence to finish, then checks each phase length, the power-down hold only when first is clear
    task automatic chk_seq(input logic [10:0] pd, input logic [14:0] gs, input logic [5:0] ph,
                           input logic [15:0] lk, input logic [12:0] rs, input logic rp,
                           input logic first);
        do
            @(posedge clock);
        while (pins.phy_reset || pins.pll_gearshift);
        repeat (2) @(posedge clock);
        if (!first)
        begin
            chk("pd hold", 32'(pd), tpf - tpr);
            chk("gs raised", 32'(rp), 32'(tgr == tpr));
        end
        chk("rst hold", 32'(rs), trf - tpf);
        chk("lock wait", 32'(lk), tlr - trf);
        chk("phy extend", 32'(ph) + 1, tphf - tcal);
        if (rp)
            chk("gs release", 32'(gs), tgf - trf);
        rd(12'h00C, 32'h8, 2'h0);
    endtask

    task automatic run(input logic [10:0] pd, input logic [14:0] gs, input logic [5:0] ph,
                       input logic [15:0] lk, input logic [12:0] rs, input logic rp);
        wr(12'h000, {pd, gs, ph}, 2'h0);
        wr(12'h004, {lk, 3'h0, rs}, 2'h0);
        wr(12'h008, {28'h0, 1'b1, rp, 2'h0}, 2'h0);
        repeat (3) @(posedge clock);
        chk_seq(pd, gs, ph, lk, rs, rp, 1'b0);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        rd(12'h000, 32'h42C2158F, 2'h0);
        rd(12'h004, 32'h00200010, 2'h0);
        rd(12'h008, 32'h4, 2'h0);
        rd(12'h010, 32'h0, 2'h2);
        chk_seq(11'h216, 15'h856, 6'hF, 16'h0020, 13'h0010, 1'b1, 1'b1);
        wr(12'h004, 32'hFFFFFFFF, 2'h0);
        rd(12'h004, 32'hFFFF1FFF, 2'h0);
        wr(12'h020, 32'h1, 2'h2);
        run(11'h005, 15'h0028, 6'hF, 16'h001E, 13'h0009, 1'b1);
        early <= 1'b1;
        run(11'h001, 15'h0003, 6'h1, 16'h0002, 13'h0001, 1'b0);
        wr(12'h008, 32'h3, 2'h0);
        repeat (4) @(posedge clock);
        rd(12'h008, 32'h3, 2'h0);
        rd(12'h00C, 32'hB, 2'h0);
        wr(12'h008, 32'h0, 2'h0);
        rd(12'h00C, 32'h8, 2'h0);
        wrap_up();
    end

    // hang guard, far beyond the few thousand cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        wrap_up();
    end
endmodule
